/* File: src/plpf_regs.svh */
// Offsets, field positions, reset values and codes of the login payload framer.
// Assumes inclusion by bare name from src files of this block.
`ifndef PLPF_REGS_SVH
`define PLPF_REGS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define PLPF_OFF_CTRL 12'h000
`define PLPF_OFF_STAT 12'h004
`define PLPF_OFF_IRQ_STAT 12'h008
`define PLPF_OFF_IRQ_MASK 12'h00c
`define PLPF_OFF_REQ_W0 12'h010
`define PLPF_OFF_REQ_PG0 12'h014
`define PLPF_OFF_SRC_ID 12'h018
`define PLPF_OFF_DST_ID 12'h01c

// ************************************************************
// Control fields
// ************************************************************
`define PLPF_CTRL_REFUSE_SCR 0
`define PLPF_CTRL_REFUSE_LOGIN 1
`define PLPF_CTRL_EST_OK 2
`define PLPF_CTRL_RSP_LSB 4
`define PLPF_CTRL_RSP_W 4
`define PLPF_CTRL_ACC_LEN_LSB 16
`define PLPF_CTRL_RESET 32'h0000_0014

// ************************************************************
// Payload codes and field positions
// ************************************************************
`define PLPF_CMD_ACC 8'h02
`define PLPF_CMD_LOGIN 8'h20
`define PLPF_CMD_SCR 8'h62
`define PLPF_CMD_RJT 8'h01
`define PLPF_PAGE_MIN 8'd12
`define PLPF_PAY_MIN 16'd16
`define PLPF_PAY_MAX 16'd256
`define PLPF_ACC_MAX 16'd65532
`define PLPF_EST_BIT 13
`define PLPF_RSP_LSB 8
`define PLPF_SPARM_MAX 7'd60

// ************************************************************
// Response codes
// ************************************************************
`define PLPF_RSP_EXEC 4'h1
`define PLPF_RSP_NORES 4'h2
`define PLPF_RSP_INIT 4'h3
`define PLPF_RSP_CFG 4'h5
`define PLPF_RSP_COND 4'h6
`define PLPF_RSP_INVAL 4'h8

// ************************************************************
// Interrupt bits
// ************************************************************
`define PLPF_IRQ_REQ_DONE 0
`define PLPF_IRQ_REQ_BAD 1
`define PLPF_IRQ_W 2

`endif

/* File: src/plpf_pkg.sv */
// Types of the login payload framer.
// Assumes plpf_regs.svh supplies the numbers.
package plpf_pkg;
    typedef enum logic [2:0] {
        PLPF_IDLE = 3'b000,
        PLPF_HDR = 3'b001,
        PLPF_PAGE = 3'b011,
        PLPF_SKIP = 3'b010,
        PLPF_REPLY = 3'b110
    } plpf_rx_st_t;
endpackage

/* File: src/plpf_chk.sv */
// Header checker of incoming process login requests.
// Assumes word 0 of the request payload at its input.
`timescale 1ns/1ps
`include "plpf_regs.svh"
module plpf_chk (
    // Request header
    input wire logic [31:0] hdr_i,
    input wire logic [23:0] sid_i,
    input wire logic [23:0] did_i,
    // Verdict
    output logic bad_o
);
    logic [7:0] pg;
    logic [15:0] pl;
    always_comb begin
        pg = hdr_i[23:16];
        pl = hdr_i[15:0];
        bad_o = 1'b0;
        if (hdr_i[31:24] != `PLPF_CMD_LOGIN) begin
            bad_o = 1'b1; // R4
        end
        if (pg[1:0] != 2'b00 || pg < `PLPF_PAGE_MIN) begin
            bad_o = 1'b1; // R18
        end
        if (pl[1:0] != 2'b00 || pl < `PLPF_PAY_MIN || pl > `PLPF_PAY_MAX) begin
            bad_o = 1'b1; // R18
        end
        if (sid_i == did_i) begin
            bad_o = 1'b1; // R3
        end
    end
endmodule

/* File: src/plpf_top.sv */
// Process login and registration reply framer with AXI4-Lite registers.
// Assumes a word stream of request payloads from same-clock link logic.
// Functional notes
// R1: Registration accept is one word: 02h then three zero bytes.
// R2: Refused registration is answered with a reject reply.
// R3: Login request carries requester in source, target in destination id.
// R4: Request word 0 top byte holds login command 20h.
// R5: Page length byte has low bits zero and is at least 12.
// R6: Payload length has low bits zero, within 16 to 256.
// R7: Page word 0 top byte is protocol type, 00h means common.
// R8: Page bit 13 asks to establish the image pair.
// R9: Optional page parameters span 0 to 60 words.
// R10: Refused login gets reject; success gets accept with 02h.
// R11: Accept page length equals request page length.
// R12: Accept payload length multiple of four, 16 to 65532.
// R13: Response page top byte carries protocol type.
// R14: Bit 13 reports image pair established, only if requested.
// R15: Bits 11-8 hold the response code.
// R16: Each response page describes exactly one pair.
// R17: Response codes follow the documented encodings.
// R18: Bad page or payload lengths are flagged for reject.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "plpf_regs.svh"
module plpf_top (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // AXI4-Lite write
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Request stream in
    input wire logic [31:0] rx_data_i,
    input wire logic rx_valid_i,
    input wire logic rx_last_i,
    input wire logic rx_scr_i,
    input wire logic [23:0] rx_sid_i,
    input wire logic [23:0] rx_did_i,
    output logic rx_ready_o,
    // Reply stream out
    output logic [31:0] tx_data_o,
    output logic tx_valid_o,
    output logic tx_last_o,
    output logic [23:0] tx_sid_o,
    output logic [23:0] tx_did_o,
    input wire logic tx_ready_i,
    // Interrupt
    output logic irq_o
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        plpf_pkg::plpf_rx_st_t st;
        logic scr;
        logic bad;
        logic [6:0] pg_idx;
        logic [31:0] w0;
        logic [31:0] pg0;
        logic [23:0] sid;
        logic [23:0] did;
        logic [31:0] ctrl;
        logic [`PLPF_IRQ_W-1:0] ist;
        logic [`PLPF_IRQ_W-1:0] imask;
        logic [1:0] tx_idx;
        logic aw_ok;
        logic w_ok;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] tx_data;
        logic tx_valid;
        logic tx_last;
        logic irq;
        logic awrdy;
        logic wrdy;
        logic ardy;
        logic rx_rdy;
    } plpf_state_t;

    plpf_state_t s_r;
    plpf_state_t s_nxt;
    logic hdr_bad;

    plpf_chk u_chk (
        .hdr_i(s_r.w0),
        .sid_i(s_r.sid),
        .did_i(s_r.did),
        .bad_o(hdr_bad)
    );

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] reply_word(input plpf_state_t s, input logic [1:0] idx);
        logic [31:0] w;
        logic [15:0] acc_len;
        logic [3:0] code;
        logic est;
        w = 32'h0000_0000;
        acc_len = s.ctrl[31:`PLPF_CTRL_ACC_LEN_LSB];
        code = s.ctrl[`PLPF_CTRL_RSP_LSB +: `PLPF_CTRL_RSP_W];
        est = s.pg0[`PLPF_EST_BIT] && s.ctrl[`PLPF_CTRL_EST_OK] &&
              (code == `PLPF_RSP_EXEC || code == `PLPF_RSP_COND); // R14
        if (idx == 2'd0) begin
            if (s.scr) begin
                w = {(s.ctrl[`PLPF_CTRL_REFUSE_SCR] ? `PLPF_CMD_RJT : `PLPF_CMD_ACC),
                     24'h00_0000}; // R1 R2
            end else if (s.bad || s.ctrl[`PLPF_CTRL_REFUSE_LOGIN]) begin
                w = {`PLPF_CMD_RJT, 24'h00_0000}; // R10
            end else begin
                if (acc_len < `PLPF_PAY_MIN) begin
                    acc_len = `PLPF_PAY_MIN;
                end
                acc_len[1:0] = 2'b00; // R12
                w = {`PLPF_CMD_ACC, s.w0[23:18], 2'b00, acc_len}; // R10 R11
            end
        end else if (idx == 2'd1) begin
            w[31:24] = s.pg0[31:24]; // R13 R16
            w[`PLPF_EST_BIT] = est; // R14
            w[`PLPF_RSP_LSB +: 4] = s.bad ? `PLPF_RSP_INVAL : code; // R15 R17
        end
        return w;
    endfunction

    always_comb begin
        logic last_tx;
        logic [`PLPF_IRQ_W-1:0] ev;
        logic [31:0] rd;
        logic [1:0] rr;
        last_tx = 1'b0;
        ev = '0;
        rd = 32'h0000_0000;
        rr = 2'b00;
        s_nxt = s_r;
        // ************************************************************
        // Request receive and reply send
        // ************************************************************
        unique case (s_r.st)
            plpf_pkg::PLPF_IDLE: begin
                if (rx_valid_i) begin
                    s_nxt.scr = rx_scr_i;
                    s_nxt.w0 = rx_data_i;
                    s_nxt.sid = rx_sid_i; // R3
                    s_nxt.did = rx_did_i; // R3
                    s_nxt.pg0 = 32'h0000_0000;
                    s_nxt.bad = 1'b0;
                    s_nxt.pg_idx = 7'd0;
                    s_nxt.st = rx_last_i ? plpf_pkg::PLPF_HDR : plpf_pkg::PLPF_PAGE;
                end
            end
            plpf_pkg::PLPF_PAGE: begin
                if (rx_valid_i) begin
                    if (s_r.pg_idx == 7'd0) begin
                        s_nxt.pg0 = rx_data_i; // R7 R8
                    end
                    s_nxt.pg_idx = s_r.pg_idx + 7'd1;
                    if (s_r.pg_idx == `PLPF_SPARM_MAX + 7'd3) begin
                        s_nxt.bad = 1'b1; // R9
                    end
                    if (rx_last_i) begin
                        s_nxt.st = plpf_pkg::PLPF_HDR;
                    end
                end
            end
            plpf_pkg::PLPF_HDR: begin
                if (!s_r.scr) begin
                    s_nxt.bad = s_r.bad || hdr_bad ||
                                s_r.pg_idx < 7'd3; // R5 R6 R18
                end
                s_nxt.st = plpf_pkg::PLPF_SKIP;
            end
            plpf_pkg::PLPF_SKIP: begin
                s_nxt.tx_idx = 2'd0;
                s_nxt.tx_data = reply_word(s_r, 2'd0);
                s_nxt.tx_valid = 1'b1;
                s_nxt.tx_last = s_r.scr || s_r.bad || s_r.ctrl[`PLPF_CTRL_REFUSE_LOGIN];
                s_nxt.st = plpf_pkg::PLPF_REPLY;
                ev[`PLPF_IRQ_REQ_BAD] = s_r.bad;
            end
            plpf_pkg::PLPF_REPLY: begin
                if (tx_ready_i) begin
                    if (s_r.tx_last) begin
                        s_nxt.tx_valid = 1'b0;
                        s_nxt.tx_last = 1'b0;
                        s_nxt.st = plpf_pkg::PLPF_IDLE;
                        last_tx = 1'b1;
                    end else begin
                        s_nxt.tx_idx = s_r.tx_idx + 2'd1;
                        s_nxt.tx_data = reply_word(s_r, s_r.tx_idx + 2'd1);
                        s_nxt.tx_last = (s_r.tx_idx == 2'd2);
                    end
                end
            end
            default: begin
                s_nxt.st = plpf_pkg::PLPF_IDLE;
            end
        endcase
        ev[`PLPF_IRQ_REQ_DONE] = last_tx;
        // ************************************************************
        // Register bus
        // ************************************************************
        if (s_axi_awvalid && !s_r.aw_ok) begin
            s_nxt.aw_ok = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.w_ok) begin
            s_nxt.w_ok = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        if (s_r.aw_ok && s_r.w_ok && !s_r.bvalid) begin
            s_nxt.aw_ok = 1'b0;
            s_nxt.w_ok = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = 2'b00;
            unique case ({s_r.awaddr[11:2], 2'b00})
                `PLPF_OFF_CTRL: s_nxt.ctrl = merge(s_r.ctrl, s_r.wdata, s_r.wstrb);
                `PLPF_OFF_IRQ_STAT: begin
                    if (s_r.wstrb[0]) begin
                        s_nxt.ist = s_r.ist & ~s_r.wdata[`PLPF_IRQ_W-1:0];
                    end
                end
                `PLPF_OFF_IRQ_MASK: begin
                    if (s_r.wstrb[0]) begin
                        s_nxt.imask = s_r.wdata[`PLPF_IRQ_W-1:0];
                    end
                end
                `PLPF_OFF_STAT, `PLPF_OFF_REQ_W0, `PLPF_OFF_REQ_PG0,
                `PLPF_OFF_SRC_ID, `PLPF_OFF_DST_ID: s_nxt.bresp = 2'b00;
                default: s_nxt.bresp = 2'b10;
            endcase
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        s_nxt.ist = s_nxt.ist | ev;
        if (s_axi_arvalid && !s_r.rvalid) begin
            unique case ({s_axi_araddr[11:2], 2'b00})
                `PLPF_OFF_CTRL: rd = s_r.ctrl;
                `PLPF_OFF_STAT: rd = {25'h0, s_r.scr, s_r.bad, 2'b00, s_r.st};
                `PLPF_OFF_IRQ_STAT: rd = {30'h0, s_r.ist};
                `PLPF_OFF_IRQ_MASK: rd = {30'h0, s_r.imask};
                `PLPF_OFF_REQ_W0: rd = s_r.w0;
                `PLPF_OFF_REQ_PG0: rd = s_r.pg0;
                `PLPF_OFF_SRC_ID: rd = {8'h00, s_r.sid};
                `PLPF_OFF_DST_ID: rd = {8'h00, s_r.did};
                default: rr = 2'b10;
            endcase
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd;
            s_nxt.rresp = rr;
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        s_nxt.irq = |(s_nxt.ist & s_nxt.imask);
        s_nxt.awrdy = !s_nxt.aw_ok;
        s_nxt.wrdy = !s_nxt.w_ok;
        s_nxt.ardy = !s_nxt.rvalid;
        s_nxt.rx_rdy = (s_nxt.st == plpf_pkg::PLPF_IDLE) || (s_nxt.st == plpf_pkg::PLPF_PAGE);
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_r <= '0;
            s_r.ctrl <= `PLPF_CTRL_RESET;
            s_r.awrdy <= 1'b1;
            s_r.wrdy <= 1'b1;
            s_r.ardy <= 1'b1;
            s_r.rx_rdy <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign s_axi_awready = s_r.awrdy;
    assign s_axi_wready = s_r.wrdy;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.ardy;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign rx_ready_o = s_r.rx_rdy;
    assign tx_data_o = s_r.tx_data;
    assign tx_valid_o = s_r.tx_valid;
    assign tx_last_o = s_r.tx_last;
    assign tx_sid_o = s_r.did;
    assign tx_did_o = s_r.sid;
    assign irq_o = s_r.irq;
endmodule

/* File: dv/plpf_monitor.sv */
// Reply stream assertions of the login payload framer.
// Assumes binding to plpf_top.
`timescale 1ns/1ps
module plpf_monitor (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [31:0] tx_data_o,
    input wire logic tx_valid_o,
    input wire logic tx_last_o,
    input wire logic tx_ready_i
);
    logic [1:0] idx_r;
    logic acc0;
    logic rsp1;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            idx_r <= 2'h0;
        else if (tx_valid_o && tx_ready_i)
            idx_r <= tx_last_o ? 2'h0 : idx_r + 2'h1;
    end
    assign acc0 = tx_valid_o && idx_r == 2'h0 && tx_data_o[31:24] == 8'h02;
    assign rsp1 = tx_valid_o && idx_r == 2'h1;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    a_scr_acc_zero: assert property (acc0 && tx_last_o |-> tx_data_o[23:0] == 24'h0)
        else $error("accept word not zero");
    a_rej_one_word: assert property (tx_valid_o && idx_r == 2'h0 && !acc0
        |-> tx_last_o && tx_data_o == 32'h0100_0000) else $error("bad reject word");
    a_acc_len_ok: assert property (acc0 && !tx_last_o
        |-> tx_data_o[1:0] == 2'h0 && tx_data_o[15:0] >= 16'h0010) else $error("accept length");
    a_page_len_ok: assert property (acc0 && !tx_last_o
        |-> tx_data_o[17:16] == 2'h0 && tx_data_o[23:16] >= 8'h0c) else $error("page length");
    a_rsp_code_enc: assert property (rsp1 |-> tx_data_o[12] == 1'b0 && tx_data_o[7:0] == 8'h0
        && tx_data_o[11:8] inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8}) else $error("code");
    a_est_needs_exec: assert property (rsp1 && tx_data_o[13]
        |-> tx_data_o[11:8] inside {4'h1, 4'h6}) else $error("established bit");
    a_one_page_only: assert property (tx_valid_o && idx_r == 2'h3 |-> tx_last_o)
        else $error("accept too long");
    a_reply_holds: assert property (tx_valid_o && !tx_ready_i
        |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o)) else $error("reply dropped");
    c_scr_acc: cover property (acc0 && tx_last_o);
    c_reject: cover property (tx_valid_o && idx_r == 2'h0 && tx_data_o[31:24] == 8'h01);
    c_est: cover property (rsp1 && tx_data_o[13]);
endmodule
bind plpf_top plpf_monitor u_mon (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o),
    .tx_ready_i(tx_ready_i));

/* File: dv/plpf_peer.sv */
// Remote port model: sends queued request words, accepts replies.
// Assumes the bench fills the queue between clock edges.
`timescale 1ns/1ps
module plpf_peer (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic rx_ready_i,
    input wire logic stall_i,
    output logic [31:0] rx_data_o,
    output logic rx_valid_o,
    output logic rx_last_o,
    output logic rx_scr_o,
    output logic [23:0] rx_sid_o,
    output logic [23:0] rx_did_o,
    output logic tx_ready_o
);
    logic [81:0] q[$];
    task automatic push(input logic [81:0] e);
        q.push_back(e);
    endtask
    assign tx_ready_o = !stall_i;
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_valid_o <= 1'b0;
            {rx_sid_o, rx_did_o, rx_scr_o, rx_last_o, rx_data_o} <= 82'h0;
        end else if (!rx_valid_o || rx_ready_i) begin
            if (q.size() > 0) begin
                {rx_sid_o, rx_did_o, rx_scr_o, rx_last_o, rx_data_o} <= q.pop_front();
                rx_valid_o <= 1'b1;
            end else begin
                rx_valid_o <= 1'b0;
                rx_data_o <= ~rx_data_o;
            end
        end
    end
endmodule

/* File: dv/process_login_payload_framer_tb.sv */
// Self-checking bench of the login payload framer.
// Assumes plpf_top, plpf_peer and plpf_regs.svh.
`timescale 1ns/1ps
`include "plpf_regs.svh"
module process_login_payload_framer_tb;
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
    logic core_clk_i = 0;
    logic rst_b_i = 0;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rx_data, tx_data, d, seed = 32'd77068;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, r;
    logic rx_valid, rx_last, rx_scr, rx_ready, tx_valid, tx_last, tx_ready, irq, stall = 1'b0;
    logic [23:0] rx_sid, rx_did, tx_sid, tx_did, s;
    logic [80:0] exp_q[$];
    logic [80:0] e;
    int miscompares = 0, check_count = 0, m_code, m_est, m_acc, m_rl, m_rs, i, n, extra = 0;
    logic [3:0] codes[6] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8};
    logic [31:0] w0s[7] = '{32'h210c_0010, 32'h200d_0010, 32'h2008_0010, 32'h200c_0012,
        32'h200c_000c, 32'h200c_0104, 32'h200c_0100};
    plpf_top DUT (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
        .rx_last_i(rx_last), .rx_scr_i(rx_scr), .rx_sid_i(rx_sid), .rx_did_i(rx_did),
        .rx_ready_o(rx_ready), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
        .tx_last_o(tx_last), .tx_sid_o(tx_sid), .tx_did_o(tx_did),
        .tx_ready_i(tx_ready), .irq_o(irq));
    plpf_peer peer (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .rx_ready_i(rx_ready),
        .stall_i(stall), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_last_o(rx_last),
        .rx_scr_o(rx_scr), .rx_sid_o(rx_sid), .rx_did_o(rx_did), .tx_ready_o(tx_ready));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task report_and_stop;
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task timeout_chk(input int k);
        if (k >= 300) begin
            miscompares++;
            report_and_stop;
        end
    endtask
    task axi_wr(input logic [11:0] a, input logic [31:0] v);
        int k;
        @(posedge core_clk_i);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (k = 0; k < 300; k++) begin
            @(posedge core_clk_i);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 0;
        timeout_chk(k);
    endtask
    task axi_rd(input logic [11:0] a);
        int k;
        @(posedge core_clk_i);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        for (k = 0; k < 300; k++) begin
            @(posedge core_clk_i);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 0;
        timeout_chk(k);
    endtask
    task set_ctrl(input int rs, input int rl, input int est, input int code);
        m_rs = rs;
        m_rl = rl;
        m_est = est;
        m_code = code;
        m_acc = 16 + rnd() % 4000;
        axi_wr(`PLPF_OFF_CTRL, {m_acc[15:0], 8'h0, m_code[3:0], 1'b0, m_est[0], m_rl[0], m_rs[0]});
    endtask
    task drain;
        for (n = 0; n < 300 && exp_q.size() > 0; n++) @(posedge core_clk_i);
        timeout_chk(n);
    endtask
    task send_scr(input logic [23:0] sd, input logic [23:0] dd);
        @(negedge core_clk_i);
        peer.push({sd, dd, 2'b11, 32'h6200_0000});
        exp_q.push_back({dd, sd, 1'b1, m_rs ? 32'h0100_0000 : 32'h0200_0000});
        drain;
    endtask
    task send(input logic [31:0] w0, input logic [31:0] p0, input logic [23:0] sd,
        input logic [23:0] dd);
        logic ok, est;
        int pl, len, j;
        pl = w0[23:16];
        len = w0[15:0];
        ok = w0[31:24] == 8'h20 && pl % 4 == 0 && pl >= 12 && len % 4 == 0 && len >= 16
            && len <= 256 && sd != dd && m_rl == 0 && extra <= 60;
        est = p0[13] && m_est != 0 && (m_code == 1 || m_code == 6);
        @(negedge core_clk_i);
        peer.push({sd, dd, 2'b00, w0});
        peer.push({sd, dd, 2'b00, p0});
        peer.push({sd, dd, 2'b00, 32'h0});
        for (j = 0; j < extra; j++) peer.push({sd, dd, 2'b00, 32'h0});
        peer.push({sd, dd, 2'b01, 32'h0});
        if (ok) begin
            exp_q.push_back({dd, sd, 1'b0, 8'h02, w0[23:16], m_acc[15:2], 2'b00});
            exp_q.push_back({dd, sd, 1'b0, p0[31:24], 10'h0, est, 1'b0, m_code[3:0], 8'h0});
            exp_q.push_back({dd, sd, 33'h0});
            exp_q.push_back({dd, sd, 33'h1_0000_0000});
        end else
            exp_q.push_back({dd, sd, 33'h1_0100_0000});
        drain;
    endtask
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        stall <= (rnd() % 4) == 0;
        if (rst_b_i && tx_valid && tx_ready) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 81'h0;
            `CHK({tx_sid, tx_did, tx_last, tx_data}, e)
        end
    end
    initial begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = 0;
        repeat (2) @(posedge core_clk_i);
        rst_b_i <= 1;
        axi_rd(`PLPF_OFF_CTRL);
        `CHK(d, `PLPF_CTRL_RESET)
        axi_rd(12'h100);
        `CHK(r, 2'b10)
        axi_rd(`PLPF_OFF_IRQ_MASK);
        `CHK(d, 32'h0)
        set_ctrl(0, 0, 1, 1);
        `CHK(r, 2'b00)
        axi_wr(12'h100, 32'h0);
        `CHK(r, 2'b10)
        send_scr(24'h01_0203, 24'hff_fffd);
        set_ctrl(1, 0, 1, 1);
        send_scr(24'h01_0204, 24'h01_0205);
        for (i = 0; i < 12; i++) begin
            set_ctrl(0, 0, i < 6, codes[i % 6]);
            d = rnd();
            s = d[23:0];
            send(32'h200c_0010, {i == 0 ? 8'h0 : d[31:24], 10'h0, i[0], 13'h0}, s, ~s);
        end
        for (i = 0; i < 7; i++) send(w0s[i], 32'h0800_2000, 24'h0a_0001, 24'h0b_0002);
        for (i = 60; i < 62; i++) begin
            extra = i;
            send(32'h200c_0010, 32'h0800_2000, 24'h0a_0001, 24'h0b_0002);
        end
        extra = 0;
        send(32'h200c_0010, 32'h0800_2000, 24'h0c_0003, 24'h0c_0003);
        set_ctrl(0, 1, 1, 1);
        send(32'h200c_0010, 32'h0800_2000, 24'h0d_0004, 24'h0e_0005);
        axi_rd(`PLPF_OFF_REQ_W0);
        `CHK(d, 32'h200c_0010)
        axi_rd(`PLPF_OFF_SRC_ID);
        `CHK(d[23:0], 24'h0d_0004)
        axi_rd(`PLPF_OFF_IRQ_STAT);
        `CHK(d[1:0], 2'b11)
        `CHK(irq, 1'b0)
        axi_wr(`PLPF_OFF_IRQ_MASK, 32'h2);
        repeat (2) @(posedge core_clk_i);
        `CHK(irq, 1'b1)
        axi_wr(`PLPF_OFF_IRQ_STAT, 32'h3);
        repeat (2) @(posedge core_clk_i);
        `CHK(irq, 1'b0)
        report_and_stop;
    end
endmodule
